// file: mspc_params.svh
// Purpose: Constants for the motion stop and preset control block
// Assumes: Included by the core module
// Notes: Byte offsets on the AHB-Lite register map
`ifndef MSPC_PARAMS_SVH
`define MSPC_PARAMS_SVH
// ==========================================================
// Register offsets
`define MSPC_OFS_CTRL 8'h00
`define MSPC_OFS_TRAVEL 8'h04
`define MSPC_OFS_PRESET 8'h08
`define MSPC_OFS_DECEL 8'h0C
`define MSPC_OFS_STATUS 8'h10
`define MSPC_OFS_CMDPOS 8'h14
`define MSPC_OFS_FBPOS 8'h18
// ==========================================================
// Control field positions
`define MSPC_CTRL_STOP_LO 0
`define MSPC_CTRL_BLK 2
`define MSPC_CTRL_LS_LO 3
`define MSPC_CTRL_HOME_LO 6
`define MSPC_CTRL_SLIT 8
`define MSPC_CTRL_ALMCLR 9
// ==========================================================
// Reset values and action codes
`define MSPC_STOP_IMM 2'h0
`define MSPC_STOP_DEC 2'h3
`define MSPC_BLK_IMM 1'h0
`define MSPC_BLK_DEC 1'h1
`define MSPC_LS_HOME 3'h7
`define MSPC_LS_IMM 3'h0
`define MSPC_LS_DEC 3'h1
`define MSPC_LS_IMM_ALM 3'h2
`define MSPC_LS_DEC_ALM 3'h3
`define MSPC_HOME_2S 2'h0
`define MSPC_HOME_3S 2'h1
`define MSPC_HOME_1WAY 2'h2
`define MSPC_TRAVEL_RST 32'h0000_0000
`define MSPC_PRESET_RST 32'h0000_0000
`define MSPC_DECEL_RST 16'h0010
// ==========================================================
// Pin vector indices
`define MSPC_PIN_FREE 0
`define MSPC_PIN_CLR 1
`define MSPC_PIN_STOP 2
`define MSPC_PIN_FBLK 3
`define MSPC_PIN_RBLK 4
`define MSPC_PIN_FLS 5
`define MSPC_PIN_RLS 6
`define MSPC_PIN_HOME_SENSOR_IN 7
`define MSPC_PIN_SLIT 8
`define MSPC_PIN_PRESET 9
`define MSPC_PIN_SFWD 10
`define MSPC_PIN_SREV 11
`define MSPC_PIN_SHOME 12
`define MSPC_PIN_TLIM 13
`define MSPC_PIN_PWR 14
`define MSPC_PIN_EXC 15
`define MSPC_NPINS 16
`endif

// file: mspc_pkg.sv
// Purpose: Types for the motion stop and preset control block
// Assumes: Nothing
// Notes: Gray-coded motion states
package mspc_pkg;
  // ==========================================================
  // Motion state
  typedef enum logic [1:0] {
    MSPC_IDLE = 2'h0,
    MSPC_RUN = 2'h1,
    MSPC_DECEL = 2'h3,
    MSPC_HOME = 2'h2
  } mspc_state_t;
endpackage

// file: mspc_core.sv
// Purpose: Stop, direction block, limit, home and preset handling
// Assumes: Pins asynchronous to clk; AHB-Lite single word transfers
// Notes: One position step per clock while moving
`timescale 1ns/1ps
`include "mspc_params.svh"

module mspc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Control pins
  input wire logic excitation_off_in,
  input wire logic deviation_clear_in,
  input wire logic stop_in,
  input wire logic fwd_block_in,
  input wire logic rev_block_in,
  input wire logic start_fwd_in,
  input wire logic start_rev_in,
  input wire logic home_start_in,
  input wire logic position_preset_in,
  input wire logic power_on_in,
  input wire logic excite_cmd_in,
  input wire logic torque_limit_in,
  // Sensors
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic home_sensor_in,
  input wire logic slit_sensor_in,
  // Status outputs
  output logic ready_out,
  output logic move_out,
  output logic in_position_out,
  output logic home_done_out,
  output logic excitation_out,
  output logic brake_release_out,
  output logic alarm_out,
  output logic fwd_prohibit_info_out,
  output logic rev_prohibit_info_out,
  output logic preset_request_info_out,
  output logic torque_limit_active_out,
  // Non-volatile store request
  output logic nv_write_out,
  output logic [31:0] nv_pos_out
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [`MSPC_NPINS-1:0] pin_raw;
  logic [`MSPC_NPINS-1:0] meta_ff;
  logic [`MSPC_NPINS-1:0] sync_ff;
  logic [`MSPC_NPINS-1:0] prev_ff;
  logic [`MSPC_NPINS-1:0] rise;
  logic [`MSPC_NPINS-1:0] fall;

  assign pin_raw = {excite_cmd_in, power_on_in, torque_limit_in,
    home_start_in, start_rev_in, start_fwd_in, position_preset_in,
    slit_sensor_in, home_sensor_in, rev_limit_in, fwd_limit_in,
    rev_block_in, fwd_block_in, stop_in, deviation_clear_in,
    excitation_off_in};

  genvar gi;
  generate
    for (gi = 0; gi < `MSPC_NPINS; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
      assign rise[gi] = sync_ff[gi] & ~prev_ff[gi];
      assign fall[gi] = ~sync_ff[gi] & prev_ff[gi];
    end
  endgenerate

  logic free_s, clr_s, stop_s, fblk_s, rblk_s, fls_s, rls_s;
  logic home_sensor_in_s, slit_s, tlim_s, pwr_s, exc_s;
  assign free_s = sync_ff[`MSPC_PIN_FREE];
  assign clr_s = sync_ff[`MSPC_PIN_CLR];
  assign stop_s = sync_ff[`MSPC_PIN_STOP];
  assign fblk_s = sync_ff[`MSPC_PIN_FBLK];
  assign rblk_s = sync_ff[`MSPC_PIN_RBLK];
  assign fls_s = sync_ff[`MSPC_PIN_FLS];
  assign rls_s = sync_ff[`MSPC_PIN_RLS];
  assign home_sensor_in_s = sync_ff[`MSPC_PIN_HOME_SENSOR_IN];
  assign slit_s = sync_ff[`MSPC_PIN_SLIT];
  assign tlim_s = sync_ff[`MSPC_PIN_TLIM];
  assign pwr_s = sync_ff[`MSPC_PIN_PWR];
  assign exc_s = sync_ff[`MSPC_PIN_EXC];

  // ==========================================================
  // Configuration registers
  logic [1:0] stop_act_ff;
  logic blk_act_ff;
  logic [2:0] ls_act_ff;
  logic [1:0] home_mode_ff;
  logic slit_use_ff;
  logic [31:0] travel_ff;
  logic [31:0] preset_ff;
  logic [15:0] decel_ff;
  logic alm_clr;

  // ==========================================================
  // AHB-Lite address and data phase
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign addr_ok = hsel & htrans[1] & hready;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_ff <= haddr;
      end
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign alm_clr = wr_pend_ff & (wr_addr_ff == `MSPC_OFS_CTRL)
    & hwdata[`MSPC_CTRL_ALMCLR];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_act_ff <= `MSPC_STOP_DEC;
      blk_act_ff <= `MSPC_BLK_IMM;
      ls_act_ff <= `MSPC_LS_IMM_ALM;
      home_mode_ff <= `MSPC_HOME_3S;
      slit_use_ff <= 1'b0;
      travel_ff <= `MSPC_TRAVEL_RST;
      preset_ff <= `MSPC_PRESET_RST;
      decel_ff <= `MSPC_DECEL_RST;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `MSPC_OFS_CTRL: begin
          stop_act_ff <= hwdata[`MSPC_CTRL_STOP_LO +: 2];
          blk_act_ff <= hwdata[`MSPC_CTRL_BLK];
          ls_act_ff <= hwdata[`MSPC_CTRL_LS_LO +: 3];
          home_mode_ff <= hwdata[`MSPC_CTRL_HOME_LO +: 2];
          slit_use_ff <= hwdata[`MSPC_CTRL_SLIT];
        end
        `MSPC_OFS_TRAVEL: travel_ff <= hwdata;
        `MSPC_OFS_PRESET: preset_ff <= hwdata;
        `MSPC_OFS_DECEL: decel_ff <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Motion state and positions
  mspc_pkg::mspc_state_t state_ff;
  logic dir_fwd_ff;
  logic [31:0] remain_ff;
  logic [15:0] dcnt_ff;
  logic [31:0] cmd_pos_ff;
  logic [31:0] fb_pos_ff;
  logic preset_busy_ff;
  logic moving;
  logic ready_cond;
  logic go_fwd, go_rev, go_home;
  logic blk_hit, ls_hit, home_found;
  logic ls_home_use;

  assign moving = (state_ff != mspc_pkg::MSPC_IDLE);
  assign ls_home_use = (ls_act_ff == `MSPC_LS_HOME);
  assign ready_cond = pwr_s & exc_s & excitation_out & ~free_s
    & ~stop_s & ~clr_s & ~alarm_out & ~moving & ~preset_busy_ff;
  assign go_fwd = ready_cond & rise[`MSPC_PIN_SFWD] & ~fblk_s;
  assign go_rev = ready_cond & rise[`MSPC_PIN_SREV] & ~rblk_s;
  assign go_home = ready_cond & rise[`MSPC_PIN_SHOME];
  assign blk_hit = (dir_fwd_ff & fblk_s) | (~dir_fwd_ff & rblk_s);
  assign ls_hit = ~ls_home_use
    & ((dir_fwd_ff & fls_s) | (~dir_fwd_ff & rls_s));

  always_comb begin
    case (home_mode_ff)
      `MSPC_HOME_2S: home_found = rls_s;
      `MSPC_HOME_3S: home_found = home_sensor_in_s;
      `MSPC_HOME_1WAY: home_found = home_sensor_in_s;
      default: home_found = home_sensor_in_s;
    endcase
    if (slit_use_ff) begin
      home_found = home_found & slit_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= mspc_pkg::MSPC_IDLE;
      dir_fwd_ff <= 1'b1;
      remain_ff <= 32'h0000_0000;
      dcnt_ff <= 16'h0000;
    end else if (clr_s | ~excitation_out) begin
      state_ff <= mspc_pkg::MSPC_IDLE;
      remain_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        mspc_pkg::MSPC_IDLE: begin
          if (go_fwd | go_rev) begin
            state_ff <= mspc_pkg::MSPC_RUN;
            dir_fwd_ff <= go_fwd;
            remain_ff <= travel_ff;
          end else if (go_home) begin
            state_ff <= mspc_pkg::MSPC_HOME;
            dir_fwd_ff <= (home_mode_ff == `MSPC_HOME_1WAY);
          end
        end
        mspc_pkg::MSPC_RUN: begin
          remain_ff <= remain_ff - 32'h0000_0001;
          dcnt_ff <= decel_ff;
          if (rise[`MSPC_PIN_STOP] | stop_s) begin
            remain_ff <= 32'h0000_0000;
            if (stop_act_ff == `MSPC_STOP_IMM) begin
              state_ff <= mspc_pkg::MSPC_IDLE;
            end else begin
              state_ff <= mspc_pkg::MSPC_DECEL;
            end
          end else if (blk_hit) begin
            remain_ff <= 32'h0000_0000;
            if (blk_act_ff == `MSPC_BLK_DEC) begin
              state_ff <= mspc_pkg::MSPC_DECEL;
            end else begin
              state_ff <= mspc_pkg::MSPC_IDLE;
            end
          end else if (ls_hit) begin
            remain_ff <= 32'h0000_0000;
            if (ls_act_ff[0]) begin
              state_ff <= mspc_pkg::MSPC_DECEL;
            end else begin
              state_ff <= mspc_pkg::MSPC_IDLE;
            end
          end else if (remain_ff <= 32'h0000_0001) begin
            state_ff <= mspc_pkg::MSPC_IDLE;
          end
        end
        mspc_pkg::MSPC_DECEL: begin
          dcnt_ff <= dcnt_ff - 16'h0001;
          if (dcnt_ff <= 16'h0001) begin
            state_ff <= mspc_pkg::MSPC_IDLE;
          end
        end
        mspc_pkg::MSPC_HOME: begin
          if (stop_s) begin
            state_ff <= mspc_pkg::MSPC_IDLE;
          end else if (home_found) begin
            state_ff <= mspc_pkg::MSPC_IDLE;
          end else if (~dir_fwd_ff & rls_s
                       & (home_mode_ff == `MSPC_HOME_3S)) begin
            dir_fwd_ff <= 1'b1;
          end else if (dir_fwd_ff & fls_s
                       & (home_mode_ff != `MSPC_HOME_1WAY)) begin
            dir_fwd_ff <= 1'b0;
          end
        end
        default: state_ff <= mspc_pkg::MSPC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Command and feedback positions, preset
  logic preset_go;
  logic home_hit;
  logic step;
  assign preset_go = rise[`MSPC_PIN_PRESET] & ~moving & ~tlim_s
    & ~preset_busy_ff;
  assign home_hit = (state_ff == mspc_pkg::MSPC_HOME) & home_found
    & ~stop_s & ~clr_s & excitation_out;
  assign step = (state_ff == mspc_pkg::MSPC_DECEL)
    | (state_ff == mspc_pkg::MSPC_HOME)
    | ((state_ff == mspc_pkg::MSPC_RUN) & ~stop_s & ~blk_hit & ~ls_hit);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_pos_ff <= 32'h0000_0000;
      fb_pos_ff <= 32'h0000_0000;
      preset_busy_ff <= 1'b0;
      nv_write_out <= 1'b0;
      nv_pos_out <= 32'h0000_0000;
    end else begin
      nv_write_out <= 1'b0;
      if (clr_s) begin
        cmd_pos_ff <= fb_pos_ff;
      end else if (preset_busy_ff) begin
        cmd_pos_ff <= preset_ff;
        fb_pos_ff <= preset_ff;
        nv_write_out <= 1'b1;
        nv_pos_out <= preset_ff;
        preset_busy_ff <= 1'b0;
      end else if (home_hit) begin
        cmd_pos_ff <= 32'h0000_0000;
        fb_pos_ff <= 32'h0000_0000;
      end else begin
        preset_busy_ff <= preset_go;
        if (step & excitation_out) begin
          cmd_pos_ff <= dir_fwd_ff ? cmd_pos_ff + 32'h0000_0001
            : cmd_pos_ff - 32'h0000_0001;
        end
        if (excitation_out & (fb_pos_ff != cmd_pos_ff)) begin
          fb_pos_ff <= ($signed(cmd_pos_ff - fb_pos_ff) > 0)
            ? fb_pos_ff + 32'h0000_0001 : fb_pos_ff - 32'h0000_0001;
        end
      end
    end
  end

  // ==========================================================
  // Excitation, brake, alarm and status outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      excitation_out <= 1'b0;
      brake_release_out <= 1'b0;
      alarm_out <= 1'b0;
      ready_out <= 1'b0;
      move_out <= 1'b0;
      in_position_out <= 1'b0;
      home_done_out <= 1'b0;
      fwd_prohibit_info_out <= 1'b0;
      rev_prohibit_info_out <= 1'b0;
      preset_request_info_out <= 1'b0;
      torque_limit_active_out <= 1'b0;
    end else begin
      excitation_out <= pwr_s & exc_s & ~free_s & ~alarm_out;
      brake_release_out <= (pwr_s & exc_s & ~free_s & ~alarm_out)
        | free_s;
      if ((state_ff == mspc_pkg::MSPC_RUN) & ls_hit & ls_act_ff[1]) begin
        alarm_out <= 1'b1;
      end else if (alm_clr) begin
        alarm_out <= 1'b0;
      end
      ready_out <= ready_cond & ~free_s;
      move_out <= moving;
      if (go_fwd | go_rev | go_home) begin
        in_position_out <= 1'b0;
      end else if ((state_ff == mspc_pkg::MSPC_RUN) & ~stop_s & ~clr_s
                   & ~blk_hit & ~ls_hit & excitation_out
                   & (remain_ff <= 32'h0000_0001)) begin
        in_position_out <= 1'b1;
      end
      if (preset_busy_ff | home_hit) begin
        home_done_out <= 1'b1;
      end else if (go_home) begin
        home_done_out <= 1'b0;
      end
      fwd_prohibit_info_out <= fblk_s;
      rev_prohibit_info_out <= rblk_s;
      preset_request_info_out <= preset_go | preset_busy_ff;
      torque_limit_active_out <= tlim_s;
    end
  end

  // ==========================================================
  // Register read mux
  assign status = {20'h0_0000, rev_prohibit_info_out, fwd_prohibit_info_out,
    preset_request_info_out, torque_limit_active_out, alarm_out,
    brake_release_out, excitation_out, home_done_out, in_position_out,
    move_out, ready_out, dir_fwd_ff};

  always_comb begin
    case (haddr)
      `MSPC_OFS_CTRL: rd_mux = {23'h00_0000, slit_use_ff, home_mode_ff,
        ls_act_ff, blk_act_ff, stop_act_ff};
      `MSPC_OFS_TRAVEL: rd_mux = travel_ff;
      `MSPC_OFS_PRESET: rd_mux = preset_ff;
      `MSPC_OFS_DECEL: rd_mux = {16'h0000, decel_ff};
      `MSPC_OFS_STATUS: rd_mux = status;
      `MSPC_OFS_CMDPOS: rd_mux = cmd_pos_ff;
      `MSPC_OFS_FBPOS: rd_mux = fb_pos_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
endmodule

// file: mspc_core_assertions.sv
// Purpose: Port-level checks for the stop and preset block
// Assumes: Pins are held for several cycles at a time
// Notes: Bound to every instance of the core
`timescale 1ns/1ps
module mspc_core_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic excitation_off_in,
  input wire logic fwd_block_in,
  input wire logic rev_block_in,
  // Status
  input wire logic ready_out,
  input wire logic move_out,
  input wire logic home_done_out,
  input wire logic excitation_out,
  input wire logic brake_release_out,
  input wire logic alarm_out,
  input wire logic fwd_prohibit_info_out,
  input wire logic rev_prohibit_info_out,
  input wire logic preset_request_info_out,
  input wire logic torque_limit_active_out,
  input wire logic nv_write_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Properties
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus)
    else $error("Bus not zero-wait OKAY");
  property p_free; excitation_off_in [*5] |->
    !excitation_out && brake_release_out && !ready_out; endproperty
  a_free: assert property (p_free)
    else $error("Free pin did not drop excitation");
  property p_hold; !excitation_off_in [*5] ##0 !excitation_out [*2]
    |-> !brake_release_out; endproperty
  a_hold: assert property (p_hold)
    else $error("Brake released while unexcited");
  property p_rdy; $rose(ready_out) |-> excitation_out; endproperty
  a_rdy: assert property (p_rdy)
    else $error("Ready before excitation");
  property p_alm; alarm_out |-> !ready_out; endproperty
  a_alm: assert property (p_alm)
    else $error("Ready during alarm");
  property p_fwd; fwd_block_in [*5] |-> fwd_prohibit_info_out; endproperty
  a_fwd: assert property (p_fwd)
    else $error("Forward prohibit missing");
  property p_rev; !rev_block_in [*5] |-> !rev_prohibit_info_out; endproperty
  a_rev: assert property (p_rev)
    else $error("Reverse prohibit without block");
  property p_tl; torque_limit_active_out [*5] |-> !preset_request_info_out;
  endproperty
  a_tl: assert property (p_tl)
    else $error("Preset under torque limit");
  property p_pmv; preset_request_info_out |-> !move_out; endproperty
  a_pmv: assert property (p_pmv)
    else $error("Preset while moving");
  property p_nv; nv_write_out |-> preset_request_info_out ##1 !nv_write_out;
  endproperty
  a_nv: assert property (p_nv)
    else $error("Store pulse wrong");
  property p_done; $rose(preset_request_info_out) |-> ##[1:2] home_done_out;
  endproperty
  a_done: assert property (p_done)
    else $error("Home done late after preset");
  c_nv: cover property (nv_write_out);
  c_alm: cover property (alarm_out);
  c_blk: cover property (fwd_prohibit_info_out && move_out);
endmodule
bind mspc_core mspc_core_assertions u_chk (.clk(clk), .reset_n(reset_n),
  .hreadyout(hreadyout), .hresp(hresp), .excitation_off_in(excitation_off_in),
  .fwd_block_in(fwd_block_in), .rev_block_in(rev_block_in),
  .ready_out(ready_out), .move_out(move_out), .home_done_out(home_done_out),
  .excitation_out(excitation_out), .brake_release_out(brake_release_out),
  .alarm_out(alarm_out), .fwd_prohibit_info_out(fwd_prohibit_info_out),
  .rev_prohibit_info_out(rev_prohibit_info_out),
  .preset_request_info_out(preset_request_info_out),
  .torque_limit_active_out(torque_limit_active_out),
  .nv_write_out(nv_write_out));

// file: mspc_sensor_model.sv
// Purpose: Limit and home sensor model
// Assumes: Trip requests come from the bench
// Notes: Slow mode adds three cycles of sensor lag
`timescale 1ns/1ps
module mspc_sensor_model (
  // Clock and control
  input wire logic clk,
  input wire logic slow,
  input wire logic fwd_trip,
  input wire logic rev_trip,
  input wire logic home_trip,
  // Sensor pins
  output logic fwd_limit,
  output logic rev_limit,
  output logic home_sensor,
  output logic slit_sensor
);
  logic [11:0] lag_ff;
  always_ff @(posedge clk) begin
    lag_ff <= {lag_ff[8:0], fwd_trip, rev_trip, home_trip};
  end
  assign {fwd_limit, rev_limit, home_sensor} = slow ? lag_ff[11:9]
    : lag_ff[2:0];
  assign slit_sensor = home_sensor;
endmodule

// file: motion_stop_and_preset_control_test.sv
// Purpose: Self-checking bench for the stop and preset block
// Assumes: Zero-wait bus slave
// Notes: Pins held long enough to pass the synchronisers
`timescale 1ns/1ps
module motion_stop_and_preset_control_test;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, nvp, ra, rb;
  logic free, clr, stp, fblk, rblk, sf, sr, shm, pre, pwr, exc, tlm;
  logic ftr, rtr, htr, slow, fls, rls, hs, slt, rdy, mv, inp, hd, ex, brk;
  logic alm, fi, ri, preq, tla, nvw;
  int failures, comparisons;
  mspc_core DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .excitation_off_in(free), .deviation_clear_in(clr), .stop_in(stp),
    .fwd_block_in(fblk), .rev_block_in(rblk), .start_fwd_in(sf),
    .start_rev_in(sr), .home_start_in(shm), .position_preset_in(pre),
    .power_on_in(pwr), .excite_cmd_in(exc), .torque_limit_in(tlm),
    .fwd_limit_in(fls), .rev_limit_in(rls), .home_sensor_in(hs),
    .slit_sensor_in(slt), .ready_out(rdy), .move_out(mv),
    .in_position_out(inp), .home_done_out(hd), .excitation_out(ex),
    .brake_release_out(brk), .alarm_out(alm), .fwd_prohibit_info_out(fi),
    .rev_prohibit_info_out(ri), .preset_request_info_out(preq),
    .torque_limit_active_out(tla), .nv_write_out(nvw), .nv_pos_out(nvp));
  mspc_sensor_model u_sens (.clk(clk), .slow(slow), .fwd_trip(ftr),
    .rev_trip(rtr), .home_trip(htr), .fwd_limit(fls), .rev_limit(rls),
    .home_sensor(hs), .slit_sensor(slt));
  // ==========================================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    ra = hrdata;
  endtask
  task go(input logic f);
    sf <= f;
    sr <= !f;
    repeat (5) @(posedge clk);
    sf <= 1'b0;
    sr <= 1'b0;
  endtask
  task wait_ready;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(rdy), 1);
  endtask
  // ==========================================================
  // Scenarios
  task t_cfg;
    logic [31:0] cfg [4];
    cfg = '{32'h0000_0038, 32'h0000_0087, 32'h0000_015F, 32'h0000_0048};
    xfer(1'b0, 8'h00, 32'h0); chk(ra, 32'h0000_0053);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h00, cfg[i]);
      xfer(1'b0, 8'h00, 32'h0); chk(ra, cfg[i]);
    end
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h1C, 32'h0); chk(ra, 32'h0000_0000);
    pwr <= 1'b1;
    exc <= 1'b1;
    wait_ready;
  endtask
  task t_stops;
    xfer(1'b1, 8'h00, 32'h0000_0050);
    xfer(1'b1, 8'h04, 32'h0000_03E8);
    go(1'b1); chk(32'(rdy), 0);
    stp <= 1'b1;
    repeat (6) @(posedge clk); chk(32'(mv), 0);
    xfer(1'b0, 8'h14, 32'h0);
    rb = ra;
    xfer(1'b0, 8'h14, 32'h0); chk(ra, rb);
    chk(32'(inp), 0);
    stp <= 1'b0;
    wait_ready;
    xfer(1'b1, 8'h00, 32'h0000_0053);
    go(1'b1);
    stp <= 1'b1;
    repeat (4) @(posedge clk);
    stp <= 1'b0;
    repeat (4) @(posedge clk); chk(32'(mv), 1);
    wait_ready;
    chk(32'(inp), 0);
  endtask
  task t_block;
    xfer(1'b1, 8'h04, 32'h0000_001E);
    go(1'b1);
    rblk <= 1'b1;
    repeat (4) @(posedge clk); chk(32'(mv), 1);
    fblk <= 1'b1;
    repeat (5) @(posedge clk); chk(32'(mv), 0);
    chk(32'(fi), 1);
    rblk <= 1'b0;
    go(1'b1); chk(32'(mv), 0);
    go(1'b0); chk(32'(mv), 1);
    wait_ready;
    fblk <= 1'b0;
    go(1'b1);
    clr <= 1'b1;
    repeat (6) @(posedge clk); chk(32'(mv), 0);
    xfer(1'b0, 8'h14, 32'h0);
    rb = ra;
    xfer(1'b0, 8'h18, 32'h0); chk(ra, rb);
    clr <= 1'b0;
    wait_ready;
  endtask
  task t_limit;
    slow <= 1'b1;
    go(1'b1);
    ftr <= 1'b1;
    repeat (12) @(posedge clk); chk({alm, ex, mv}, 32'h4);
    ftr <= 1'b0;
    xfer(1'b1, 8'h00, 32'h0000_0253);
    wait_ready;
    slow <= 1'b0;
    xfer(1'b1, 8'h00, 32'h0000_0078);
    go(1'b1);
    ftr <= 1'b1;
    repeat (6) @(posedge clk); chk(32'(mv), 1);
    wait_ready;
    ftr <= 1'b0;
  endtask
  task t_preset;
    xfer(1'b1, 8'h08, 32'h0000_1234);
    pre <= 1'b1;
    repeat (8) @(posedge clk);
    pre <= 1'b0;
    chk(nvp, 32'h0000_1234);
    chk(32'(hd), 32'h0000_0001);
    xfer(1'b0, 8'h18, 32'h0); chk(ra, 32'h0000_1234);
    tlm <= 1'b1;
    xfer(1'b1, 8'h08, 32'h0000_5678);
    pre <= 1'b1;
    repeat (8) @(posedge clk);
    pre <= 1'b0;
    xfer(1'b0, 8'h14, 32'h0); chk(ra, 32'h0000_1234);
    tlm <= 1'b0;
    go(1'b1);
    pre <= 1'b1;
    repeat (4) @(posedge clk);
    pre <= 1'b0; chk(nvp, 32'h0000_1234);
    wait_ready;
  endtask
  task t_free;
    free <= 1'b1;
    repeat (6) @(posedge clk); chk({ex, brk, rdy}, 32'h2);
    free <= 1'b0;
    wait_ready;
    exc <= 1'b0;
    repeat (6) @(posedge clk); chk(32'(brk), 0);
    free <= 1'b1;
    repeat (6) @(posedge clk); chk(32'(brk), 1);
  endtask
  task conclude;
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    failures = 0;
    comparisons = 0;
    {hsel, hwrite, htrans, haddr, hwdata, free, clr, stp, fblk, rblk} = '0;
    {sf, sr, shm, pre, pwr, exc, tlm, ftr, rtr, htr, slow} = '0;
    hsize = 3'h2;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_cfg;
    t_stops;
    t_block;
    t_limit;
    t_preset;
    t_free;
    conclude;
  end
  initial begin
    #500000;
    failures++;
    $display("CHECK FAILED %0t watchdog", $time);
    conclude;
  end
endmodule
